// ==== core/pmas_params.svh ====
// register offsets, control field positions, reset values and timing constants of the sequencer
`ifndef PMAS_PARAMS_SVH
`define PMAS_PARAMS_SVH
`define PMAS_OFS_CTRL 8'h00
`define PMAS_OFS_SHUNT_HI 8'h01
`define PMAS_OFS_SHUNT_LO 8'h02
`define PMAS_OFS_SUPPLY_HI 8'h03
`define PMAS_OFS_SUPPLY_LO 8'h04
`define PMAS_OFS_AUX_HI 8'h05
`define PMAS_OFS_AUX_LO 8'h06
`define PMAS_CTRL_SNAP_EN 7
`define PMAS_CTRL_CH_HI 6
`define PMAS_CTRL_CH_LO 5
`define PMAS_CTRL_BUSY 3
`define PMAS_CTRL_SUP_HI 2
`define PMAS_CTRL_SHDN 1
`define PMAS_CTRL_SUP_LO 0
`define PMAS_CTRL_RESET 8'h05
`define PMAS_CTRL_WMASK 8'hf7
`define PMAS_RES_W 12
`define PMAS_NUM_CH 64'd3
`define PMAS_CLK_HZ 64'd200000000
`define PMAS_REFRESH_DHZ 64'd75
`define PMAS_CONV_CYCLES int'((`PMAS_CLK_HZ * 64'd10) / (`PMAS_REFRESH_DHZ * `PMAS_NUM_CH))
`define PMAS_SHUNT_LSB_NV 25000
`define PMAS_SUPPLY_LSB_UV 25000
`define PMAS_AUX_LSB_UV 500
`endif

// ==== core/pmas_pkg.sv ====
// types and helpers shared by the measurement sequencer
package pmas_pkg;
    typedef enum logic [1:0] {PMAS_CH_SHUNT, PMAS_CH_SUPPLY, PMAS_CH_AUX} pmas_chan_t;
    typedef enum logic [1:0] {PMAS_SRC_SENSE_POS, PMAS_SRC_HV_PIN, PMAS_SRC_AUX} pmas_src_t;
    typedef enum {PMAS_ST_OFF, PMAS_ST_SCAN, PMAS_ST_SNAP, PMAS_ST_HALT} pmas_state_t;

    function automatic pmas_chan_t pmas_next_chan(input pmas_chan_t ch);
        unique case (ch)
            PMAS_CH_SHUNT: pmas_next_chan = PMAS_CH_SUPPLY;
            PMAS_CH_SUPPLY: pmas_next_chan = PMAS_CH_AUX;
            PMAS_CH_AUX: pmas_next_chan = PMAS_CH_SHUNT;
            default: pmas_next_chan = PMAS_CH_SHUNT;
        endcase
    endfunction : pmas_next_chan
endpackage : pmas_pkg

// ==== core/pmas_conv_timer.sv ====
// conversion window timer: one done pulse per window that runs to its end without abort or restart
`timescale 1ns/1ps
module pmas_conv_timer #(
    parameter int unsigned CYCLES = 8888888
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic running_o,
    output logic done_o
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
            running_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt <= '0;
                running_o <= 1'b1;
            end else if (abort_i) begin
                running_o <= 1'b0;
            end else if (running_o) begin
                if (cnt == CW'(CYCLES - 1)) begin
                    running_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt <= cnt + CW'(1);
                end
            end
        end
    end
endmodule : pmas_conv_timer

// ==== core/pmas_sequencer.sv ====
// measurement sequencer: scan and snapshot control, result registers, lockout and shutdown
// Operation
// - continuous scan converts shunt, then supply, then auxiliary, repeating.
// - shunt result code weighs 25 uV per step, 102.4 mV full scale.
// - supply result code weighs 25 mV per step, 102.4 V full scale.
// - auxiliary result code weighs 0.5 mV per step, 2.048 V full scale.
// - result split over two bytes: top eight bits, then four bits over zeros.
// - a channel's result pair refreshes right after its conversion ends.
// - completed snapshot write starts the selected conversion and raises busy.
// - snapshot conversion end halts converter and drops busy.
// - serial logic and converter enable once either supply passes lockout.
// - converter off only with both supplies low; serial reset likewise.
// - shutdown bit powers down converter and reference.
// - in shutdown address pins ignored, last latched address kept.
// - in shutdown all registers keep contents and stay accessible.
// - clearing shutdown powers analog back up and resumes scanning; with the snapshot bit set it halts.
// - in shutdown the on-board regulator is disabled.
// - two control bits choose the supply channel source.
`timescale 1ns/1ps
`include "pmas_params.svh"
module pmas_sequencer import pmas_pkg::*; #(
    parameter int unsigned CONV_CYCLES = `PMAS_CONV_CYCLES,
    parameter logic [1:0] SNAP_CODE_SHUNT = 2'h0,
    parameter logic [1:0] SNAP_CODE_SUPPLY = 2'h1,
    parameter logic [1:0] SNAP_CODE_AUX = 2'h2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic adc_start_o,
    output pmas_chan_t adc_channel_o,
    output pmas_src_t supply_source_o,
    input wire logic [`PMAS_RES_W-1:0] adc_result_i,
    output logic adc_powerdown_o,
    output logic regulator_disable_o,
    output logic serial_enable_o,
    input wire logic high_supply_above_uvlo_i,
    input wire logic low_supply_pin_above_uvlo_i,
    input wire logic high_supply_above_serial_rst_i,
    input wire logic low_supply_pin_above_serial_rst_i,
    input wire logic [1:0] addr_select_hi_i,
    input wire logic [1:0] addr_select_lo_i,
    output logic [1:0] addr_latched_hi_o,
    output logic [1:0] addr_latched_lo_o
);
    localparam int RW = `PMAS_RES_W;

    logic rst_ff1;
    logic rst_n;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic hv_uvlo, lv_uvlo, hv_srst, lv_srst;
    logic adc_on;
    logic serial_en;
    logic [7:0] ctrl;
    logic busy;
    logic shutdown;
    logic active;
    logic ctrl_wr;
    logic snap_req;
    logic scan_req;
    logic conv_start;
    logic conv_abort;
    logic conv_done;
    pmas_state_t state, next_state;
    pmas_chan_t cur_ch, next_ch;
    logic [2:0][RW-1:0] res;

    function automatic pmas_chan_t snap_map(input logic [1:0] code);
        if (code == SNAP_CODE_SUPPLY) begin
            snap_map = PMAS_CH_SUPPLY;
        end else if (code == SNAP_CODE_AUX) begin
            snap_map = PMAS_CH_AUX;
        end else begin
            snap_map = PMAS_CH_SHUNT;
        end
    endfunction : snap_map

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_ff1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_ff1 <= 1'b1;
            rst_n <= rst_ff1;
        end
    end

    // comparator and strap levels are asynchronous to clk_i
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
        end else begin
            pin_s1 <= {high_supply_above_uvlo_i, low_supply_pin_above_uvlo_i, high_supply_above_serial_rst_i,
                       low_supply_pin_above_serial_rst_i, addr_select_hi_i, addr_select_lo_i};
            pin_s2 <= pin_s1;
        end
    end
    assign {hv_uvlo, lv_uvlo, hv_srst, lv_srst} = pin_s2[7:4];

    assign adc_on = hv_uvlo | lv_uvlo;

    // serial logic has hysteresis: it drops only below the lower reset thresholds
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            serial_en <= 1'b0;
        end else if (hv_uvlo || lv_uvlo) begin
            serial_en <= 1'b1;
        end else if (!hv_srst && !lv_srst) begin
            serial_en <= 1'b0;
        end
    end
    assign serial_enable_o = serial_en;

    assign ctrl_wr = reg_wr_i && serial_en && (reg_addr_i == `PMAS_OFS_CTRL);
    // a snapshot word that also sets shutdown does not start a conversion
    assign snap_req = ctrl_wr && reg_wdata_i[`PMAS_CTRL_SNAP_EN] && !reg_wdata_i[`PMAS_CTRL_SHDN];
    assign scan_req = ctrl_wr && !reg_wdata_i[`PMAS_CTRL_SNAP_EN];

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `PMAS_CTRL_RESET;
        end else if (!serial_en) begin
            ctrl <= `PMAS_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= reg_wdata_i & `PMAS_CTRL_WMASK;
        end
    end
    assign shutdown = ctrl[`PMAS_CTRL_SHDN];
    assign active = adc_on && serial_en && !shutdown;
    assign regulator_disable_o = shutdown;

    always_comb begin
        next_state = state;
        unique case (state)
            PMAS_ST_OFF: begin
                if (active) begin
                    if (snap_req) begin
                        next_state = PMAS_ST_SNAP;
                    end else if (ctrl[`PMAS_CTRL_SNAP_EN] && !scan_req) begin
                        next_state = PMAS_ST_HALT;
                    end else begin
                        next_state = PMAS_ST_SCAN;
                    end
                end
            end
            PMAS_ST_SCAN, PMAS_ST_SNAP, PMAS_ST_HALT: begin
                if (!active) begin
                    next_state = PMAS_ST_OFF;
                end else if (snap_req) begin
                    next_state = PMAS_ST_SNAP;
                end else if (scan_req) begin
                    next_state = PMAS_ST_SCAN;
                end else if (state == PMAS_ST_SNAP && conv_done) begin
                    next_state = PMAS_ST_HALT;
                end
            end
        endcase
    end

    always_comb begin
        conv_start = 1'b0;
        next_ch = cur_ch;
        if (next_state == PMAS_ST_SNAP && (snap_req || state != PMAS_ST_SNAP)) begin
            conv_start = 1'b1;
            next_ch = snap_map(reg_wdata_i[`PMAS_CTRL_CH_HI:`PMAS_CTRL_CH_LO]);
        end else if (next_state == PMAS_ST_SCAN && state != PMAS_ST_SCAN) begin
            conv_start = 1'b1;
            next_ch = PMAS_CH_SHUNT;
        end else if (state == PMAS_ST_SCAN && next_state == PMAS_ST_SCAN && conv_done) begin
            conv_start = 1'b1;
            next_ch = pmas_next_chan(cur_ch);
        end
    end
    assign conv_abort = (next_state == PMAS_ST_OFF) || (next_state == PMAS_ST_HALT);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= PMAS_ST_OFF;
            cur_ch <= PMAS_CH_SHUNT;
            busy <= 1'b0;
            adc_start_o <= 1'b0;
            adc_powerdown_o <= 1'b1;
        end else begin
            state <= next_state;
            cur_ch <= next_ch;
            busy <= (next_state == PMAS_ST_SNAP);
            adc_start_o <= conv_start;
            adc_powerdown_o <= !active;
        end
    end
    assign adc_channel_o = cur_ch;

    pmas_conv_timer #(
        .CYCLES(CONV_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .start_i(conv_start),
        .abort_i(conv_abort),
        .running_o(),
        .done_o(conv_done)
    );

    // results are raw codes; step weights 25 uV, 25 mV and 0.5 mV are applied by software
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            res <= '0;
        end else if (!serial_en) begin
            res <= '0;
        end else if (conv_done) begin
            res[cur_ch] <= adc_result_i;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                `PMAS_OFS_SHUNT_HI: res[0][RW-1:4] <= reg_wdata_i;
                `PMAS_OFS_SHUNT_LO: res[0][3:0] <= reg_wdata_i[7:4];
                `PMAS_OFS_SUPPLY_HI: res[1][RW-1:4] <= reg_wdata_i;
                `PMAS_OFS_SUPPLY_LO: res[1][3:0] <= reg_wdata_i[7:4];
                `PMAS_OFS_AUX_HI: res[2][RW-1:4] <= reg_wdata_i;
                `PMAS_OFS_AUX_LO: res[2][3:0] <= reg_wdata_i[7:4];
                default: res <= res;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `PMAS_OFS_CTRL: reg_rdata_o <= {ctrl[7:4], busy, ctrl[2:0]};
                `PMAS_OFS_SHUNT_HI: reg_rdata_o <= res[0][RW-1:4];
                `PMAS_OFS_SHUNT_LO: reg_rdata_o <= {res[0][3:0], 4'h0};
                `PMAS_OFS_SUPPLY_HI: reg_rdata_o <= res[1][RW-1:4];
                `PMAS_OFS_SUPPLY_LO: reg_rdata_o <= {res[1][3:0], 4'h0};
                `PMAS_OFS_AUX_HI: reg_rdata_o <= res[2][RW-1:4];
                `PMAS_OFS_AUX_LO: reg_rdata_o <= {res[2][3:0], 4'h0};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    always_comb begin
        unique case ({ctrl[`PMAS_CTRL_SUP_HI], ctrl[`PMAS_CTRL_SUP_LO]})
            2'b01: supply_source_o = PMAS_SRC_HV_PIN;
            2'b10: supply_source_o = PMAS_SRC_AUX;
            default: supply_source_o = PMAS_SRC_SENSE_POS;
        endcase
    end

    // the strap is frozen in shutdown so pin pull-ups may be powered off
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_latched_hi_o <= 2'h0;
            addr_latched_lo_o <= 2'h0;
        end else if (!shutdown) begin
            addr_latched_hi_o <= pin_s2[3:2];
            addr_latched_lo_o <= pin_s2[1:0];
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    scan_order_a: assert property ((state == PMAS_ST_SCAN) && conv_done && (next_state == PMAS_ST_SCAN)
        |=> adc_start_o && (cur_ch == pmas_next_chan($past(cur_ch))))
        else $error("scan did not advance to the next channel");

    low_nibble_a: assert property (reg_rd_i && (reg_addr_i == `PMAS_OFS_AUX_LO)
        |=> reg_rdata_o[3:0] == 4'h0)
        else $error("low result byte has nonzero low nibble");

    result_store_a: assert property (conv_done && serial_en
        |=> res[$past(cur_ch)] == $past(adc_result_i))
        else $error("result not stored after conversion");

    busy_set_a: assert property (snap_req && active |=> busy && adc_start_o ##1 busy)
        else $error("snapshot did not start with busy");

    busy_clear_a: assert property ((state == PMAS_ST_SNAP) && conv_done && active && !ctrl_wr
        |=> !busy && (state == PMAS_ST_HALT))
        else $error("snapshot end did not clear busy and halt");

    halt_hold_a: assert property ((state == PMAS_ST_HALT) && !reg_wr_i |=> !adc_start_o)
        else $error("converter restarted while halted");

    uvlo_on_a: assert property (!serial_en && (hv_uvlo || lv_uvlo) |=> serial_en)
        else $error("serial logic not enabled above lockout");

    serial_keep_a: assert property (serial_en && (hv_srst || lv_srst) |=> serial_en)
        else $error("serial logic reset with a supply present");

    shdn_power_a: assert property (shutdown |-> regulator_disable_o ##1 adc_powerdown_o)
        else $error("shutdown did not power down analog");

    addr_keep_a: assert property (shutdown |=> $stable(addr_latched_hi_o) && $stable(addr_latched_lo_o))
        else $error("address changed in shutdown");

    regs_keep_a: assert property (shutdown && serial_en && (state == PMAS_ST_OFF) && !reg_wr_i
        |=> $stable(res))
        else $error("results changed in shutdown");

    resume_a: assert property ($fell(shutdown) && adc_on && serial_en && !ctrl[`PMAS_CTRL_SNAP_EN]
        && !ctrl_wr |=> adc_start_o && (cur_ch == PMAS_CH_SHUNT))
        else $error("conversions did not resume after shutdown");

    snap_map_a: assert property (snap_req && active
        && (reg_wdata_i[`PMAS_CTRL_CH_HI:`PMAS_CTRL_CH_LO] == SNAP_CODE_AUX) |=> cur_ch == PMAS_CH_AUX)
        else $error("snapshot code mapped to wrong channel");

    snap_done_c: cover property ((state == PMAS_ST_SNAP) ##1 (state == PMAS_ST_HALT));
    scan_wrap_c: cover property ((state == PMAS_ST_SCAN) && conv_done && (cur_ch == PMAS_CH_AUX));
    shdn_resume_c: cover property (shutdown ##1 !shutdown ##1 adc_start_o);
    uvlo_drop_c: cover property (serial_en ##1 !serial_en);
endmodule : pmas_sequencer

// ==== verif/pmas_adc_model.sv ====
// converter stand-in for the sequencer bench: holds one code per conversion window
`timescale 1ns/1ps
module pmas_adc_model #(
    parameter int unsigned CONV_CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [11:0] code_i,
    output logic [11:0] result_o
);
    logic [11:0] held = 12'h000;
    int unsigned left = 0;
    // a new start restarts the window, as an aborted conversion would
    always_ff @(posedge clk_i) begin
        if (start_i) begin
            held <= code_i;
            left <= CONV_CYCLES + 1;
        end else if (left != 0) begin
            left <= left - 1;
        end
    end
    // outside a window the inverse shows, so a late sample never reads as fresh data
    assign result_o = (left != 0) ? held : ~held;
endmodule : pmas_adc_model

// ==== verif/test_power_monitor_adc_sequencer.sv ====
// self-checking bench for the measurement sequencer
`timescale 1ns/1ps
`include "pmas_params.svh"
module test_power_monitor_adc_sequencer import pmas_pkg::*;;
    localparam int unsigned CONV = 20;
    localparam logic [1:0] SC [3] = '{2'h0, 2'h1, 2'h2};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic start;
    pmas_chan_t chan;
    pmas_src_t src;
    logic [11:0] res;
    logic [11:0] code = 12'h123;
    logic pd, regd, sen;
    logic hu = 1'b1, lu = 1'b1, hs = 1'b1, ls = 1'b1;
    logic [1:0] ash = 2'h1, asl = 2'h2, alh, all;
    logic [11:0] pend [4];
    logic [11:0] done [4] = '{default: 12'h000};
    logic [31:0] seed = 32'd26;
    int err_total = 0, checks = 0, cyc = 0, n_start = 0, last = 0, live = 0;
    int seq [$];

    always #2.5 clk = ~clk;

    pmas_sequencer #(.CONV_CYCLES(CONV), .SNAP_CODE_SHUNT(SC[0]), .SNAP_CODE_SUPPLY(SC[1]),
        .SNAP_CODE_AUX(SC[2])) u_dut (.clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .adc_start_o(start),
        .adc_channel_o(chan), .supply_source_o(src), .adc_result_i(res), .adc_powerdown_o(pd),
        .regulator_disable_o(regd), .serial_enable_o(sen), .high_supply_above_uvlo_i(hu),
        .low_supply_pin_above_uvlo_i(lu), .high_supply_above_serial_rst_i(hs),
        .low_supply_pin_above_serial_rst_i(ls), .addr_select_hi_i(ash), .addr_select_lo_i(asl),
        .addr_latched_hi_o(alh), .addr_latched_lo_o(all));

    pmas_adc_model #(.CONV_CYCLES(CONV)) u_adc (.clk_i(clk), .start_i(start), .code_i(code),
        .result_o(res));

    function automatic logic [11:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[11:0];
    endfunction : rnd

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        wr_s = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr_s = 1'b0;
        // a control write may abort the running window, so its capture is not expected
        if (a == `PMAS_OFS_CTRL) live = 0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        rd_s = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd_s = 1'b0;
        d = rdata;
    endtask : rd

    task automatic chk_res(input int ch, input logic [11:0] exp);
        logic [7:0] h, l;
        rd(`PMAS_OFS_SHUNT_HI + 8'(2 * ch), h);
        rd(`PMAS_OFS_SHUNT_LO + 8'(2 * ch), l);
        chk({4'h0, h}, {4'h0, exp[11:4]});
        chk({4'h0, l}, {4'h0, exp[3:0], 4'h0});
    endtask : chk_res

    task automatic wait_start(input int n0, input int cnt);
        for (int i = 0; i < 300 && n_start < n0 + cnt; i++) @(posedge clk);
    endtask : wait_start

    // the monitor remembers which code each window was given and commits it when the next window starts
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (start) begin
            if (live != 0) done[last] = pend[last];
            pend[chan] = code;
            last = int'(chan);
            live = 1;
            seq.push_back(int'(chan));
            n_start++;
            code <= rnd();
        end
        if (pd) live = 0;
        // the ceiling is several times the expected run length; running out counts as a mismatch
        if (cyc > 5000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        logic [7:0] d;
        logic [1:0] h0, l0;
        int n0;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 50 && sen !== 1'b1; i++) @(posedge clk);
        rd(`PMAS_OFS_CTRL, d);
        chk({4'h0, d}, {4'h0, `PMAS_CTRL_RESET});
        $display("reset test done");

        n0 = n_start;
        wait_start(n0, 7);
        // scan has run since reset, so the start count, not the loop index, gives the channel
        for (int k = 0; k < 7; k++) chk(12'(seq[n0 + k]), 12'((n0 + k) % 3));
        wait_start(n_start, 1);
        for (int k = 0; k < 3; k++) chk_res(k, done[k]);
        rd(8'h20, d);
        chk({4'h0, d}, 12'h000);
        wr(`PMAS_OFS_CTRL, 8'h0d);
        rd(`PMAS_OFS_CTRL, d);
        chk({4'h0, d}, 12'h005);
        $display("scan test done");

        for (int k = 0; k < 3; k++) begin
            if (k == 0) code = 12'hfff;
            // every snapshot needs its own control write
            wr(`PMAS_OFS_CTRL, 8'h85 | {1'b0, SC[k], 5'h00});
            chk({10'h0, chan}, 12'(k));
            rd(`PMAS_OFS_CTRL, d);
            chk({11'h0, d[`PMAS_CTRL_BUSY]}, 12'h001);
            for (int i = 0; i < 40 && d[`PMAS_CTRL_BUSY] !== 1'b0; i++) rd(`PMAS_OFS_CTRL, d);
            chk({11'h0, d[`PMAS_CTRL_BUSY]}, 12'h000);
            chk_res(k, pend[k]);
            n0 = n_start;
            repeat (3 * CONV) @(posedge clk);
            chk(12'(n_start - n0), 12'h000);
        end
        $display("snapshot test done");

        for (int k = 0; k < 4; k++) begin
            wr(`PMAS_OFS_CTRL, {5'h00, k[1], 1'b0, k[0]});
            chk({10'h0, src}, (k == 1) ? 12'h001 : (k == 2) ? 12'h002 : 12'h000);
        end
        wr(`PMAS_OFS_CTRL, 8'h05);
        $display("supply select test done");

        // the bench's bus needs no regulator power, so shutdown is safe here
        wr(`PMAS_OFS_CTRL, 8'h07);
        repeat (2) @(posedge clk);
        chk({11'h0, pd}, 12'h001);
        chk({11'h0, regd}, 12'h001);
        h0 = ash;
        l0 = asl;
        chk({8'h0, alh, all}, {8'h0, h0, l0});
        ash <= ~ash;
        asl <= ~asl;
        n0 = n_start;
        repeat (10) @(posedge clk);
        chk({8'h0, alh, all}, {8'h0, h0, l0});
        wr(`PMAS_OFS_SHUNT_HI, 8'h5a);
        wr(`PMAS_OFS_SHUNT_LO, 8'hff);
        chk_res(0, 12'h5af);
        rd(`PMAS_OFS_CTRL, d);
        chk({4'h0, d}, 12'h007);
        chk(12'(n_start - n0), 12'h000);
        wr(`PMAS_OFS_CTRL, 8'h05);
        wait_start(n0, 1);
        chk({11'h0, pd}, 12'h000);
        chk(12'(seq[n0]), 12'h000);
        chk({8'h0, alh, all}, {8'h0, ash, asl});
        chk_res(0, 12'h5af);
        $display("shutdown test done");

        hu <= 1'b0;
        repeat (10) @(posedge clk);
        chk({11'h0, pd}, 12'h000);
        lu <= 1'b0;
        repeat (10) @(posedge clk);
        chk({11'h0, pd}, 12'h001);
        hs <= 1'b0;
        repeat (10) @(posedge clk);
        chk({11'h0, sen}, 12'h001);
        ls <= 1'b0;
        repeat (10) @(posedge clk);
        chk({11'h0, sen}, 12'h000);
        wr(`PMAS_OFS_CTRL, 8'h07);
        lu <= 1'b1;
        ls <= 1'b1;
        repeat (10) @(posedge clk);
        chk({11'h0, sen}, 12'h001);
        chk({11'h0, pd}, 12'h000);
        rd(`PMAS_OFS_CTRL, d);
        chk({4'h0, d}, 12'h005);
        hu <= 1'b1;
        hs <= 1'b1;
        $display("lockout test done");
        give_verdict();
    end
endmodule : test_power_monitor_adc_sequencer
